// [src/rmec_pkg.sv]
// Shared constants and types for the regulator mode and enable control
package rmec_pkg;
	localparam int CLK_MHZ = 100;
	localparam int PWM_KHZ = 1000;
	localparam int PWM_CYC = CLK_MHZ * 1000 / PWM_KHZ;
	localparam logic [6:0] PWM_LAST = 7'(PWM_CYC - 1);
	localparam logic [6:0] PWM_MIN_ON = 7'h0A;
	localparam int MODE_ENTRY = 64;
	localparam logic [6:0] ENTRY_CNT = 7'(MODE_ENTRY);
	localparam int POWERUP_US = 100;
	localparam int CORE_MIN_MV = 600;
	localparam int CORE_MAX_MV = 1200;
	localparam int CORE_STEPS = 128;
	localparam logic [6:0] CORE_DEFAULT = 7'h7F;
	localparam int FORCED_LIMIT_MA = 100;
	// Mode force field (two top bits of the force register)
	localparam logic [1:0] FORCE_DEFAULT = 2'h0;
	localparam logic [1:0] FORCE_PSKIP = 2'h2;
	localparam logic [1:0] FORCE_FIXED = 2'h1;
	localparam logic [5:0] FORCE_LOW_ZERO = 6'h00;
	// Register addresses
	localparam logic [3:0] ADDR_CORE = 4'h0;
	localparam logic [3:0] ADDR_FORCE = 4'h9;
	// Link commands
	localparam logic [3:0] CMD_VOLT = 4'h1;
	localparam logic [3:0] CMD_RESET = 4'h2;
	localparam logic [3:0] CMD_SLEEP = 4'h3;
	localparam logic [3:0] CMD_SHUT = 4'h4;
	localparam logic [3:0] CMD_WAKE = 4'h5;
	localparam logic [3:0] CMD_READ = 4'h6;
	localparam logic [3:0] CMD_WRITE = 4'h7;
	localparam logic [3:0] CMD_AUTH = 4'h8;
	localparam logic [3:0] CMD_SYNC = 4'h9;
	// Arbitrary identity byte returned on authenticate
	localparam logic [7:0] DEVICE_ID = 8'h5A;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	localparam logic [4:0] RESP_BITS = 5'h08;
	// Input vector positions
	localparam int IN_LOW = 0;
	localparam int IN_HIGH = 1;
	localparam int IN_PEAK = 2;
	localparam int IN_ZERO = 3;
	localparam int IN_VALLEY = 4;
	localparam int IN_BELOW = 5;
	localparam int IN_LIMIT = 6;
	localparam int IN_EN = 7;
	localparam int IN_RSTN = 8;
	localparam int IN_W = 9;
	typedef enum logic [4:0] {
		ST_STARTUP = 5'h01,
		ST_POWERUP = 5'h02,
		ST_ACTIVE = 5'h04,
		ST_SLEEP = 5'h08,
		ST_SHUT = 5'h10
	} rmec_pwr_t;
	typedef enum logic [3:0] {
		PF_IDLE = 4'h1,
		PF_HIGH = 4'h2,
		PF_PEAKLOW = 4'h4,
		PF_COAST = 4'h8
	} rmec_pfm_t;
	typedef enum logic [3:0] {
		LK_IDLE = 4'h1,
		LK_RECV = 4'h2,
		LK_WAIT = 4'h4,
		LK_SEND = 4'h8
	} rmec_lnk_t;
endpackage

// [src/rmec_regulator_control.sv]
// Regulator mode, switch and enable control with a serial command link
// Notes on behaviour
// RULE1: Core voltage code is 7 bits, 128 linear steps from 0.6 V to 1.2 V.
// RULE2: Link accepts voltage, reset, sleep, shutdown, wakeup, read, write, auth, sync.
// RULE3: Fixed-frequency mode runs 1 MHz: high side first, then low side.
// RULE4: Auto mode enters pulse skipping after entry condition holds 64 cycles.
// RULE5: Pulse skipping: low comparator turns high side on until high or peak trip.
// RULE6: After peak trip, low side conducts; high side returns at zero current.
// RULE7: After high trip, high side waits for low trip; low side off at zero.
// RULE8: Mode is automatic by default; force setting can pin either mode.
// RULE9: Forced pulse skipping selects the reduced 100 mA switch current limit.
// RULE10: Peak current limit cuts the high side in every mode.
// RULE11: Runs only with both enable pins high; either low shuts down.
// RULE12: Enabling runs power-up and restores all voltage settings to defaults.
// RULE13: Shutdown command disables link and regulators until pins re-enable.
// RULE14: Controller re-enables after shutdown by toggling enable pins high-low-high.
// RULE15: Enable and reset pins may be tied together as one enable.
// RULE16: Start-up: regulators off, power good low; active: all on, power good high.
// RULE17: Sleep: core off, power good high, memory retention; wakeup restores active.
// RULE18: Force field bits 7:6: equal means auto, 10 pulse skip, 01 fixed.
// RULE19: Auto mode returns to fixed frequency once entry conditions stop holding.
`timescale 1ns/1ps
module rmec_regulator_control
	import rmec_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_US * CLK_MHZ
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic linkClk,
	input wire logic enablePin,
	input wire logic chipResetLow,
	input wire logic lowComp,
	input wire logic highComp,
	input wire logic pulsePeakCurrent,
	input wire logic zeroCurrent,
	input wire logic valleyNegative,
	input wire logic peakBelowMode,
	input wire logic currentLimit,
	input wire logic linkDataIn,
	output logic linkDataOut,
	output logic linkDataOe,
	output logic highSide,
	output logic lowSide,
	output logic coreRegOn,
	output logic ldoOn,
	output logic memRetention,
	output logic powerGood,
	output logic pulseSkipMode,
	output logic reducedLimit,
	output logic [6:0] coreVoltageCode
);
	localparam logic [15:0] PU_LAST = 16'(POWERUP_CYCLES - 1);

	// Command match on an accepted frame
	function automatic logic cmdIs(input logic evt, input logic [3:0] code, input logic [3:0] want);
		return evt && (code == want);
	endfunction

	// Pin and comparator inputs, three stages, change taken when the last two agree
	wire [IN_W-1:0] rawIn = {chipResetLow, enablePin, currentLimit, peakBelowMode,
		valleyNegative, zeroCurrent, pulsePeakCurrent, highComp, lowComp};
	logic [IN_W-1:0] inA, inB, inC, inF;
	for (genvar i = 0; i < IN_W; i++) begin : g_sync
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				{inA[i], inB[i], inC[i], inF[i]} <= 4'h0;
			end else begin
				{inA[i], inB[i], inC[i]} <= {rawIn[i], inA[i], inB[i]};
				if (inB[i] == inC[i]) begin
					inF[i] <= inC[i];
				end
			end
		end
	end

	wire lowC = inF[IN_LOW];
	wire highC = inF[IN_HIGH];
	wire peakC = inF[IN_PEAK];
	wire zeroC = inF[IN_ZERO];
	wire limC = inF[IN_LIMIT];
	wire pinsOn = inF[IN_EN] && inF[IN_RSTN]; // RULE11

	// Link-side signals
	rmec_lnk_t lnkState, next_lnk;
	logic [15:0] frameWord;
	logic [14:0] shiftIn;
	logic [7:0] shiftOut;
	logic [4:0] bitCnt;
	logic reqToggle, onA, onB, onC, onF, rsA, rsB, rsC, rsF, rsSeen;

	// Core-side signals
	rmec_pwr_t pwrState, next_pwr;
	rmec_pfm_t pfmState, next_pfm;
	logic [15:0] pwrCnt;
	logic [6:0] coreCode, entryCnt, pwmCnt;
	logic [1:0] forceBits;
	logic [7:0] respData;
	logic respToggle, linkOn, limLatch, rqA, rqB, rqC, rqSeen;

	// Request toggle from the link, three stages
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{rqA, rqB, rqC, rqSeen} <= 4'h0;
		end else begin
			{rqA, rqB, rqC} <= {reqToggle, rqA, rqB};
			if (rqB == rqC) begin
				rqSeen <= rqC;
			end
		end
	end

	// Frame decode; traffic counts only while the link is enabled
	wire reqEvt = linkOn && (rqB == rqC) && (rqC != rqSeen); // RULE13
	wire [3:0] fCmd = frameWord[15:12];
	wire [3:0] fAddr = frameWord[11:8];
	wire [7:0] fData = frameWord[7:0];
	wire cmdShut = cmdIs(reqEvt, fCmd, CMD_SHUT);
	wire cmdReset = cmdIs(reqEvt, fCmd, CMD_RESET);
	wire cmdSleep = cmdIs(reqEvt, fCmd, CMD_SLEEP);
	wire cmdWake = cmdIs(reqEvt, fCmd, CMD_WAKE);
	wire cmdVolt = cmdIs(reqEvt, fCmd, CMD_VOLT);
	wire cmdWrite = cmdIs(reqEvt, fCmd, CMD_WRITE);
	wire cmdResp = cmdIs(reqEvt, fCmd, CMD_READ) || cmdIs(reqEvt, fCmd, CMD_AUTH); // RULE2
	wire wrCore = cmdVolt || (cmdWrite && fAddr == ADDR_CORE); // RULE1
	wire wrForce = cmdWrite && fAddr == ADDR_FORCE;
	wire [7:0] readValue = (fCmd == CMD_AUTH) ? DEVICE_ID :
		(fAddr == ADDR_CORE) ? {1'b0, coreCode} :
		(fAddr == ADDR_FORCE) ? {forceBits, FORCE_LOW_ZERO} : 8'h00;

	// Power state sequencing
	always_comb begin
		next_pwr = pwrState;
		unique case (pwrState)
			ST_STARTUP: if (pinsOn) next_pwr = ST_POWERUP;
			ST_POWERUP: if (pwrCnt == PU_LAST) next_pwr = ST_ACTIVE;
			ST_ACTIVE: begin
				if (cmdShut) next_pwr = ST_SHUT; // RULE13
				else if (cmdReset) next_pwr = ST_POWERUP;
				else if (cmdSleep) next_pwr = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (cmdShut) next_pwr = ST_SHUT;
				else if (cmdReset) next_pwr = ST_POWERUP;
				else if (cmdWake) next_pwr = ST_ACTIVE; // RULE17
			end
			ST_SHUT: next_pwr = ST_SHUT;
			default: next_pwr = ST_STARTUP;
		endcase
		if (!pinsOn) next_pwr = ST_STARTUP; // RULE11 RULE14
	end

	wire enterPu = (next_pwr == ST_POWERUP) && (pwrState != ST_POWERUP);

	// State, power-up timer and voltage settings
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pwrState <= ST_STARTUP;
			pwrCnt <= 16'h0000;
			coreCode <= CORE_DEFAULT;
			forceBits <= FORCE_DEFAULT;
			respData <= 8'h00;
			respToggle <= 1'b0;
		end else begin
			pwrState <= next_pwr;
			pwrCnt <= enterPu ? 16'h0000 : pwrCnt + 16'h0001;
			if (enterPu) begin
				coreCode <= CORE_DEFAULT; // RULE12
				forceBits <= FORCE_DEFAULT;
			end else begin
				if (wrCore) coreCode <= fData[6:0]; // RULE1
				if (wrForce) forceBits <= fData[7:6]; // RULE18
			end
			if (cmdResp) begin
				respData <= readValue;
				respToggle <= ~respToggle;
			end
		end
	end

	// Supply and status outputs follow the power state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{coreRegOn, ldoOn, memRetention, powerGood, linkOn} <= 5'h00;
			coreVoltageCode <= CORE_DEFAULT;
		end else begin
			coreRegOn <= pwrState == ST_POWERUP || pwrState == ST_ACTIVE; // RULE16
			ldoOn <= pwrState == ST_POWERUP || pwrState == ST_ACTIVE || pwrState == ST_SLEEP;
			memRetention <= pwrState == ST_SLEEP; // RULE17
			powerGood <= pwrState == ST_ACTIVE || pwrState == ST_SLEEP; // RULE16
			linkOn <= pwrState == ST_ACTIVE || pwrState == ST_SLEEP; // RULE13
			coreVoltageCode <= coreCode;
		end
	end

	// Mode selection
	wire autoSel = forceBits[1] == forceBits[0]; // RULE8 RULE18
	wire forcePskip = forceBits == FORCE_PSKIP;
	wire forceFixed = forceBits == FORCE_FIXED;
	wire entryCond = inF[IN_VALLEY] || inF[IN_BELOW];
	wire entryMet = entryCnt == ENTRY_CNT;
	wire next_pskip = forcePskip || (!forceFixed && entryCond && (entryMet || pulseSkipMode)); // RULE4 RULE19

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			entryCnt <= 7'h00;
			{pulseSkipMode, reducedLimit} <= 2'h0;
		end else begin
			entryCnt <= !entryCond ? 7'h00 : entryMet ? entryCnt : entryCnt + 7'h01; // RULE4
			pulseSkipMode <= next_pskip;
			reducedLimit <= forcePskip; // RULE9
		end
	end

	// Fixed-frequency timing
	wire run = coreRegOn;
	wire [6:0] onTime = PWM_MIN_ON + {1'b0, coreCode[6:1]};
	wire pwmEnd = pwmCnt == PWM_LAST;
	wire pwmHigh = run && !pulseSkipMode && (pwmCnt < onTime) && !limLatch && !limC; // RULE3 RULE10
	wire pwmLow = run && !pulseSkipMode && !pwmHigh; // RULE3

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{pwmCnt, limLatch} <= 8'h00;
		end else begin
			pwmCnt <= pwmEnd ? 7'h00 : pwmCnt + 7'h01;
			limLatch <= limC || (limLatch && !pwmEnd); // RULE10
		end
	end

	// Pulse-skipping switch sequencing
	always_comb begin
		next_pfm = pfmState;
		unique case (pfmState)
			PF_IDLE: if (lowC) next_pfm = PF_HIGH; // RULE5
			PF_HIGH: begin
				if (highC) next_pfm = PF_COAST; // RULE5
				else if (peakC || limC) next_pfm = PF_PEAKLOW;
			end
			PF_PEAKLOW: if (zeroC) next_pfm = highC ? PF_IDLE : PF_HIGH; // RULE6
			PF_COAST: begin
				if (lowC) next_pfm = PF_HIGH; // RULE7
				else if (zeroC) next_pfm = PF_IDLE;
			end
			default: next_pfm = PF_IDLE;
		endcase
		if (!run || !pulseSkipMode) next_pfm = PF_IDLE;
	end

	wire pfmOn = run && pulseSkipMode;
	wire pfmHigh = pfmOn && pfmState == PF_HIGH && !limC; // RULE10
	wire pfmLow = pfmOn && (pfmState == PF_PEAKLOW || pfmState == PF_COAST); // RULE6 RULE7

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pfmState <= PF_IDLE;
			{highSide, lowSide} <= 2'h0;
		end else begin
			pfmState <= next_pfm;
			highSide <= pwmHigh || pfmHigh;
			lowSide <= pwmLow || pfmLow;
		end
	end

	// Link domain: enable level and response toggle, three stages each
	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			{onA, onB, onC, onF} <= 4'h0;
			{rsA, rsB, rsC, rsF} <= 4'h0;
		end else begin
			{onA, onB, onC} <= {linkOn, onA, onB};
			if (onB == onC) onF <= onC;
			{rsA, rsB, rsC} <= {respToggle, rsA, rsB};
			if (rsB == rsC) rsF <= rsC;
		end
	end

	// Frame engine: start bit, then command, address and data
	wire lastBit = bitCnt == FRAME_LAST;
	wire [3:0] rxCmd = shiftIn[14:11];
	wire wantResp = rxCmd == CMD_READ || rxCmd == CMD_AUTH;
	wire respReady = rsF != rsSeen;
	wire sendDone = bitCnt == RESP_BITS - 5'h01; // Bit 7 leaves on the wait edge, so eight bits in all

	always_comb begin
		next_lnk = lnkState;
		unique case (lnkState)
			LK_IDLE: if (linkDataIn) next_lnk = LK_RECV;
			LK_RECV: if (lastBit) next_lnk = wantResp ? LK_WAIT : LK_IDLE;
			LK_WAIT: if (respReady) next_lnk = LK_SEND;
			LK_SEND: if (sendDone) next_lnk = LK_IDLE;
			default: next_lnk = LK_IDLE;
		endcase
		if (!onF) next_lnk = LK_IDLE; // RULE13
	end

	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			lnkState <= LK_IDLE;
			{bitCnt, shiftIn} <= 20'h0_0000;
		end else begin
			lnkState <= next_lnk;
			bitCnt <= (next_lnk != lnkState) ? 5'h00 : bitCnt + 5'h01;
			if (lnkState == LK_RECV) shiftIn <= {shiftIn[13:0], linkDataIn};
		end
	end

	// Frame hand-off to the core domain
	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			{frameWord, reqToggle} <= 17'h0_0000;
		end else if (onF && lnkState == LK_RECV && lastBit) begin
			frameWord <= {shiftIn, linkDataIn}; // RULE2
			reqToggle <= ~reqToggle;
		end
	end

	// Response shifter drives the data pin, most significant bit first
	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			{rsSeen, linkDataOut, linkDataOe} <= 3'h0;
			shiftOut <= 8'h00;
		end else begin
			if (!onF || (lnkState == LK_WAIT && respReady)) rsSeen <= rsF;
			if (next_lnk == LK_SEND) begin
				shiftOut <= (lnkState == LK_WAIT) ? {respData[6:0], 1'b0} : {shiftOut[6:0], 1'b0};
				linkDataOut <= (lnkState == LK_WAIT) ? respData[7] : shiftOut[7];
				linkDataOe <= 1'b1;
			end else begin
				linkDataOut <= 1'b0;
				linkDataOe <= 1'b0;
			end
		end
	end

	// Checks in the core clock domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	switch_overlap_a: assert property (!(highSide && lowSide)) else $error("both switches on"); // RULE3
	pwm_phase_a: assert property (run && !pulseSkipMode && !limC && !limLatch && pwmCnt == 7'h00 |=> highSide) // RULE3
		else $error("fixed period not starting high");
	auto_entry_a: assert property (autoSel && entryCond [*8] ##0 entryCnt == ENTRY_CNT |=> pulseSkipMode) // RULE4
		else $error("auto entry missed");
	auto_exit_a: assert property (autoSel && !entryCond |=> !pulseSkipMode) else $error("auto exit missed"); // RULE19
	force_mode_a: assert property (forcePskip |=> pulseSkipMode && reducedLimit) // RULE18
		else $error("forced mode not applied");
	fixed_force_a: assert property (forceFixed |=> !pulseSkipMode && !reducedLimit) // RULE8
		else $error("fixed force not applied");
	pfm_start_a: assert property (pfmState == PF_IDLE && pfmOn && lowC |=> pfmState == PF_HIGH) // RULE5
		else $error("low trip ignored");
	peak_hold_a: assert property (pfmOn && pfmState == PF_PEAKLOW && !zeroC |=> lowSide && !highSide) // RULE6
		else $error("peak recovery wrong");
	coast_hold_a: assert property (pfmOn && pfmState == PF_COAST && !lowC |=> !highSide) // RULE7
		else $error("high side during coast");
	limit_cut_a: assert property (limC |=> !highSide) else $error("limit did not cut high side"); // RULE10
	pin_off_a: assert property (!pinsOn |=> pwrState == ST_STARTUP ##1 !powerGood && !coreRegOn) // RULE11
		else $error("pins low did not shut down");
	startup_out_a: assert property (pwrState == ST_STARTUP |=> !powerGood && !coreRegOn) // RULE16
		else $error("startup outputs wrong");
	sleep_out_a: assert property (pwrState == ST_SLEEP |=> powerGood && !coreRegOn && memRetention) // RULE17
		else $error("sleep outputs wrong");
	shut_link_a: assert property (pwrState == ST_SHUT |=> !linkOn && !powerGood && !ldoOn) // RULE13
		else $error("shutdown left link on");
	pu_default_a: assert property (enterPu |=> coreCode == CORE_DEFAULT && forceBits == FORCE_DEFAULT) // RULE12
		else $error("defaults not restored");
endmodule

// [tb/rmec_link_ctrl.sv]
// Processor-side power controller model that drives the serial link
`timescale 1ns/1ps
module rmec_link_ctrl (
	output logic linkClk,
	output logic linkDataIn,
	input wire logic linkDataOut,
	input wire logic linkDataOe
);
	logic drv;
	// Wire level: the device value while it drives, else ours
	assign linkDataIn = linkDataOe ? linkDataOut : drv;
	initial begin
		linkClk = 1'b0;
		drv = 1'b0;
	end
	// One 6 ns link period; the clock stands low outside frames
	task automatic tick();
		#3 linkClk = 1'b1;
		#3 linkClk = 1'b0;
	endtask
	// Idle lead-in, start bit, 16 bits MSB first, then clocks for the answer
	task automatic xfer(input logic [15:0] frame, output logic [7:0] ans, output int nBits);
		logic [16:0] bits;
		bits = {1'b1, frame};
		ans = 8'h00;
		nBits = 0;
		repeat (10) tick();
		for (int i = 16; i >= 0; i--) begin
			drv = bits[i];
			tick();
		end
		drv = 1'b0;
		// Each answer bit is taken before the edge that replaces it
		for (int i = 0; i < 30; i++) begin
			if (linkDataOe === 1'b1) begin
				ans = {ans[6:0], linkDataOut};
				nBits++;
			end
			tick();
		end
	endtask
endmodule

// [tb/rmec_regulator_control_tb.sv]
// Self-checking bench for the regulator mode and enable control
`timescale 1ns/1ps
module rmec_regulator_control_tb;
	import rmec_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic enablePin = 1'b0;
	logic chipResetLow = 1'b0;
	logic lowComp = 1'b0;
	logic highComp = 1'b0;
	logic pulsePeakCurrent = 1'b0;
	logic zeroCurrent = 1'b0;
	logic valleyNegative = 1'b0;
	logic peakBelowMode = 1'b0;
	logic currentLimit = 1'b0;
	logic linkClk, linkDataIn, linkDataOut, linkDataOe, highSide, lowSide, coreRegOn, ldoOn;
	logic memRetention, powerGood, pulseSkipMode, reducedLimit;
	logic [6:0] coreVoltageCode;
	logic [7:0] ans;
	int nBits;
	int miscompares = 0;
	int nTests = 0;

	rmec_regulator_control #(.POWERUP_CYCLES(20)) rmec_regulator_control_i (
		.clk(clk), .reset(reset), .linkClk(linkClk), .enablePin(enablePin), .chipResetLow(chipResetLow),
		.lowComp(lowComp), .highComp(highComp), .pulsePeakCurrent(pulsePeakCurrent),
		.zeroCurrent(zeroCurrent), .valleyNegative(valleyNegative), .peakBelowMode(peakBelowMode),
		.currentLimit(currentLimit), .linkDataIn(linkDataIn), .linkDataOut(linkDataOut),
		.linkDataOe(linkDataOe), .highSide(highSide), .lowSide(lowSide), .coreRegOn(coreRegOn),
		.ldoOn(ldoOn), .memRetention(memRetention), .powerGood(powerGood), .pulseSkipMode(pulseSkipMode),
		.reducedLimit(reducedLimit), .coreVoltageCode(coreVoltageCode)
	);
	rmec_link_ctrl rmec_link_ctrl_i (
		.linkClk(linkClk), .linkDataIn(linkDataIn), .linkDataOut(linkDataOut), .linkDataOe(linkDataOe)
	);

	// 100 MHz core clock
	always #5 clk = ~clk;

	task automatic chkBit(input string what, input logic exp, input logic got);
		nTests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkNum(input string what, input int exp, input int got);
		nTests++;
		if (got != exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
		rmec_link_ctrl_i.xfer({c, a, d}, ans, nBits);
		cyc(1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		cmd(CMD_READ, a, 8'h00);
		chkNum("answer bits", 8, nBits);
		chkByte("read data", exp, ans);
	endtask
	task automatic waitPg();
		int n;
		n = 0;
		while (powerGood !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		cyc(10);
	endtask
	task automatic waitHs(input logic lvl, output int n);
		n = 0;
		while (highSide !== lvl && n < 300) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_powerup();
		chkByte("code at reset", {1'b0, CORE_DEFAULT}, {1'b0, coreVoltageCode});
		chkBit("good at reset", 1'b0, powerGood);
		enablePin = 1'b1;
		cyc(50);
		chkBit("good with reset pin low", 1'b0, powerGood);
		chkBit("core off in startup", 1'b0, coreRegOn);
		chipResetLow = 1'b1;
		waitPg();
		chkBit("good when active", 1'b1, powerGood);
		chkBit("core on when active", 1'b1, coreRegOn);
		chkBit("ldo on when active", 1'b1, ldoOn);
		$display("power-up test done");
	endtask
	task automatic t_link();
		cmd(CMD_VOLT, ADDR_CORE, 8'h00);
		chkByte("min code", 8'h00, {1'b0, coreVoltageCode});
		rd(ADDR_CORE, 8'h00);
		cmd(CMD_WRITE, ADDR_CORE, 8'h7F);
		rd(ADDR_CORE, 8'h7F);
		cmd(CMD_AUTH, 4'h0, 8'h00);
		chkByte("auth id", DEVICE_ID, ans);
		cmd(CMD_SYNC, 4'h0, 8'h00);
		chkNum("sync answer bits", 0, nBits);
		cmd(CMD_WRITE, 4'h3, 8'hA5);
		rd(4'h3, 8'h00);
		rd(ADDR_FORCE, {FORCE_DEFAULT, FORCE_LOW_ZERO});
		$display("link test done");
	endtask
	task automatic t_modes();
		logic [1:0] f [4] = '{FORCE_DEFAULT, 2'h3, FORCE_PSKIP, FORCE_FIXED};
		for (int i = 0; i < 4; i++) begin
			cmd(CMD_WRITE, ADDR_FORCE, {f[i], FORCE_LOW_ZERO});
			rd(ADDR_FORCE, {f[i], FORCE_LOW_ZERO});
			valleyNegative = (i % 2 == 0);
			peakBelowMode = (i % 2 == 1);
			cyc(50);
			chkBit("early mode", f[i] == FORCE_PSKIP, pulseSkipMode);
			cyc(30);
			chkBit("entered mode", f[i] != FORCE_FIXED, pulseSkipMode);
			chkBit("reduced limit", f[i] == FORCE_PSKIP, reducedLimit);
			valleyNegative = 1'b0;
			peakBelowMode = 1'b0;
			cyc(10);
			chkBit("left mode", f[i] == FORCE_PSKIP, pulseSkipMode);
		end
		$display("mode test done");
	endtask
	task automatic t_pfm();
		cmd(CMD_WRITE, ADDR_FORCE, {FORCE_PSKIP, FORCE_LOW_ZERO});
		lowComp = 1'b1;
		cyc(10);
		chkBit("high on low trip", 1'b1, highSide);
		lowComp = 1'b0;
		highComp = 1'b1;
		cyc(10);
		chkBit("high off upper trip", 1'b0, highSide);
		chkBit("low side after upper", 1'b1, lowSide);
		zeroCurrent = 1'b1;
		cyc(10);
		chkBit("low side at zero", 1'b0, lowSide);
		chkBit("high waits low trip", 1'b0, highSide);
		zeroCurrent = 1'b0;
		highComp = 1'b0;
		lowComp = 1'b1;
		cyc(10);
		lowComp = 1'b0;
		pulsePeakCurrent = 1'b1;
		cyc(10);
		chkBit("high off peak trip", 1'b0, highSide);
		chkBit("low side after peak", 1'b1, lowSide);
		pulsePeakCurrent = 1'b0;
		zeroCurrent = 1'b1;
		cyc(10);
		chkBit("high back at zero", 1'b1, highSide);
		highComp = 1'b1;
		cyc(10);
		chkBit("high off again", 1'b0, highSide);
		highComp = 1'b0;
		zeroCurrent = 1'b0;
		$display("pulse skip test done");
	endtask
	task automatic t_pwm();
		int hi, per, n;
		cmd(CMD_WRITE, ADDR_FORCE, {FORCE_FIXED, FORCE_LOW_ZERO});
		cmd(CMD_VOLT, ADDR_CORE, 8'h20);
		waitHs(1'b0, n);
		waitHs(1'b1, n);
		waitHs(1'b0, hi);
		cyc(2);
		chkBit("low side in second phase", 1'b1, lowSide);
		waitHs(1'b1, per);
		chkNum("on time", 26, hi);
		chkNum("period", 100, hi + 2 + per);
		currentLimit = 1'b1;
		cyc(10);
		waitHs(1'b1, n);
		chkNum("high under limit", 300, n);
		currentLimit = 1'b0;
		$display("fixed frequency test done");
	endtask
	task automatic t_sleep();
		cmd(CMD_VOLT, ADDR_CORE, 8'h33);
		cmd(CMD_SLEEP, 4'h0, 8'h00);
		chkBit("core off in sleep", 1'b0, coreRegOn);
		chkBit("good in sleep", 1'b1, powerGood);
		chkBit("retention in sleep", 1'b1, memRetention);
		cmd(CMD_WAKE, 4'h0, 8'h00);
		chkBit("core after wake", 1'b1, coreRegOn);
		rd(ADDR_CORE, 8'h33);
		cmd(CMD_RESET, 4'h0, 8'h00);
		waitPg();
		chkByte("code after reset cmd", {1'b0, CORE_DEFAULT}, {1'b0, coreVoltageCode});
		$display("sleep test done");
	endtask
	task automatic t_shut();
		cmd(CMD_VOLT, ADDR_CORE, 8'h10);
		cmd(CMD_SHUT, 4'h0, 8'h00);
		chkBit("good after shutdown", 1'b0, powerGood);
		chkBit("core after shutdown", 1'b0, coreRegOn);
		cmd(CMD_AUTH, 4'h0, 8'h00);
		chkNum("answer bits in shutdown", 0, nBits);
		chipResetLow = 1'b0;
		cyc(10);
		chipResetLow = 1'b1;
		waitPg();
		chkBit("good after toggle", 1'b1, powerGood);
		chkByte("code after toggle", {1'b0, CORE_DEFAULT}, {1'b0, coreVoltageCode});
		enablePin = 1'b0;
		cyc(10);
		chkBit("good with enable low", 1'b0, powerGood);
		chipResetLow = 1'b0;
		cyc(10);
		{enablePin, chipResetLow} = 2'b11;
		waitPg();
		chkBit("good with tied pins", 1'b1, powerGood);
		$display("shutdown test done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Main sequence: reset for two cycles, then the scenarios
	initial begin
		rmec_link_ctrl_i.tick();
		repeat (2) @(negedge clk);
		reset = 1'b0;
		t_powerup();
		t_link();
		t_modes();
		t_pfm();
		t_pwm();
		t_sleep();
		t_shut();
		complete_run();
	end

	// Watchdog that cuts a hang short
	initial begin
		#400000;
		miscompares++;
		complete_run();
	end
endmodule
